// ---- logic/dat_translate.sv ----
// Host/PCI address translation, decode and page policy for DRAM rows
`default_nettype none
// Function
// - Row and column share a 13-bit address bus, 14 bits with 64-Mbit support
// - Page size is fixed at 2K bytes for hit detection
// - Address lines are built only from address bits 26 to 3, except sync column line 10
// - Row phase: line13 A24, line12 A23, line11 A11, lines10-0 A22-A12
// - Column phase: lines7-0 A10-A3, line12 A23, lines11-8 geometry choices
// - Synchronous column line 10 high during init, low in normal use
// - Lines 11 and 12 are bank selects; upper only with 64-Mbit support
// - Policy bit set: page stays open until a page or row miss
// - Policy bit clear: page open only while host busy or PCI owns bus
// - After reset every row runs as fast page type
// - Extended data out rows allow early column strobe release
// - Above top, video buffer or gaps go to PCI, not cacheable
// - Hidden memory is not remapped; video memory reachable for SMM only
// - Segments from 768 KB to 1 MB have individually selectable cacheability
// - Decoded main memory space is at most 256 MB
// - Fast page/EXTENDED_DATA_OUT_TYPE rows: 10-12 row bits, 9-12 column bits
// - Synchronous rows: 12-14 row bits, 8-10 column bits
// - x4 synchronous devices work functionally
// - 64-Mbit enable turns two row pins into line 13 and upper bank select
// - Each row runs with the type configured for that row
module dat_translate (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire dat_pkg::dat_req_s i_req,
  input  wire logic              i_req_valid,
  output logic                   o_req_ready,
  input  wire logic              i_keep_open,
  input  wire logic              i_host_busy,
  input  wire logic              i_pci_owner,
  input  wire logic              i_sdram_64m_en,
  input  wire logic              i_sdram_init,
  input  wire logic              i_smm_access,
  input  wire logic              i_smram_en,
  input  wire logic              i_gap_en,
  input  wire logic [15:0]       i_seg_cache,
  input  wire dat_pkg::dat_bound_t i_row_bound,
  input  wire logic              i_cfg_load,
  input  wire dat_pkg::dat_type_t i_row_type,
  input  wire dat_pkg::dat_geom_t i_row_geom,
  output logic [13:0]            o_mux_address_lines,
  output logic                   o_bank_select_low,
  output logic                   o_bank_select_high,
  output logic                   o_row_phase,
  output logic                   o_col_phase,
  output logic [5:0]             o_row_sel,
  output logic                   o_row_pin4,
  output logic                   o_row_pin5,
  output dat_pkg::dat_mem_e      o_row_type,
  output logic                   o_early_cas_release,
  output dat_pkg::dat_stat_s     o_status,
  output logic                   o_fwd_pci
);
  import dat_pkg::*;

  dat_state_e        state_q;
  dat_req_s          req_q;
  dat_stat_s         stat_q;
  logic [MA_W-1:0]   ma_q;
  logic [ROWS-1:0]   sel_q;
  logic              fwd_q;
  logic [2:0]        row_q;
  dat_mem_e          cur_type_q;
  logic              open_q;
  logic [2:0]        open_row_q;
  logic [27:PAGE_LSB] open_page_q;
  dat_type_t         type_q;
  dat_geom_t         geom_q;

  // Incoming address decode
  wire [31:3] a        = i_req.addr;
  wire        accept   = i_req_valid && (state_q == ST_IDLE);
  wire        beyond   = |a[31:SPACE_LSB];
  wire [BOUND_W-1:0] unit_idx = {2'h0, a[SPACE_LSB-1:UNIT_LSB]};
  wire        above_top = unit_idx >= i_row_bound[ROWS-1];
  wire        video    = a[31:VIDEO_LSB] == VIDEO_BLK;
  wire        video_smm = video && i_smm_access && i_smram_en;
  wire        gap      = i_gap_en && (a[31:20] == GAP_MB);
  wire        to_pci   = beyond || above_top || (video && !video_smm) || gap;
  wire        low_seg  = (a[31:20] == LOW_MB) && (a[19:18] == SEG_WIN);
  wire [3:0]  seg_idx  = a[SEG_LSB+3:SEG_LSB];
  wire        seg_ok   = !low_seg || i_seg_cache[seg_idx];
  wire        cacheable = !to_pci && !video && seg_ok;

  // Row decode from cumulative boundaries in 4 MB units
  logic [ROWS-1:0] below;
  logic [ROWS-1:0] row_hit;
  genvar g;
  generate
    for (g = 0; g < ROWS; g++) begin : g_row
      assign below[g] = unit_idx < i_row_bound[g];
      if (g == 0) begin : g_first
        assign row_hit[g] = below[g];
      end else begin : g_next
        assign row_hit[g] = below[g] && !below[g-1];
      end
    end
  endgenerate

  function automatic logic [2:0] enc(input logic [ROWS-1:0] oh);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < ROWS; i++) begin
      if (oh[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  wire [2:0]  row_idx   = enc(row_hit);
  wire [27:PAGE_LSB] page = a[27:PAGE_LSB];

  // Page classification against the single open page
  wire same_row  = open_q && (open_row_q == row_idx);
  wire page_hit  = same_row && (open_page_q == page);
  wire page_miss = same_row && (open_page_q != page);
  wire row_miss  = !same_row;
  wire go_dram   = accept && !to_pci;

  // Row phase mapping
  function automatic logic [MA_W-1:0] row_ma(input logic [31:3] x, input logic en64);
    logic [MA_W-1:0] m;
    m        = '0;
    m[13]    = en64 ? x[24] : 1'b0;
    m[12]    = x[23];
    m[11]    = x[11];
    m[10:0]  = x[22:12];
    return m;
  endfunction

  // Column phase mapping; geometry 0 is the narrowest column width
  function automatic logic [MA_W-1:0] col_ma(input logic [31:3] x, input logic [GEOM_W-1:0] gm,
                                             input logic sd, input logic init);
    logic [MA_W-1:0] m;
    m       = '0;
    m[7:0]  = x[10:3];
    m[12]   = x[23];
    m[11]   = (gm == 2'h0) ? x[26] : x[11];
    m[10]   = sd ? init : ((gm == 2'h0) ? x[11] : x[25]);
    unique case (gm)
      2'h0: m[9] = x[11];
      2'h1: m[9] = x[24];
      default: m[9] = x[26];
    endcase
    unique case (gm)
      2'h0: m[8] = x[11];
      2'h1: m[8] = x[22];
      2'h2: m[8] = x[23];
      2'h3: m[8] = x[25];
    endcase
    return m;
  endfunction

  // Geometry and type of the row being started or in progress
  wire [2:0]          use_row  = accept ? row_idx : row_q;
  wire [31:3]         use_addr = accept ? a : req_q.addr;
  wire dat_mem_e      use_type = type_q[use_row];
  wire [GEOM_W-1:0]   use_geom = geom_q[use_row];
  wire                use_sd   = use_type == SYNC_DRAM_TYPE;
  wire [MA_W-1:0]     ma_row   = row_ma(use_addr, i_sdram_64m_en);
  wire [MA_W-1:0]     ma_col   = col_ma(use_addr, use_geom, use_sd, i_sdram_init);
  wire                idle_close = !i_keep_open && !i_host_busy && !i_pci_owner;
  wire                hold_idle  = (state_q == ST_IDLE) && !accept;

  // Per-row configuration; every row starts as fast page type
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      type_q <= '{default: TYPE_RESET};
      geom_q <= {ROWS{GEOM_RESET}};
    end else if (i_cfg_load) begin
      type_q <= i_row_type;
      geom_q <= i_row_geom;
    end
  end

  // Access sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q    <= ST_IDLE;
      req_q      <= '0;
      stat_q     <= '0;
      ma_q       <= '0;
      sel_q      <= '0;
      row_q      <= 3'h0;
      fwd_q      <= 1'b0;
      cur_type_q <= TYPE_RESET;
    end else begin
      fwd_q <= accept && to_pci;
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            req_q  <= i_req;
            row_q  <= row_idx;
            stat_q <= '{page_hit: page_hit && !to_pci, page_miss: page_miss && !to_pci,
                        row_miss: row_miss && !to_pci, to_pci: to_pci, cacheable: cacheable};
          end
          if (go_dram) begin
            sel_q      <= row_hit;
            cur_type_q <= use_type;
            ma_q       <= page_hit ? ma_col : ma_row;
            state_q    <= page_hit ? ST_COL : ST_ROW;
          end else begin
            sel_q <= '0;
          end
        end
        ST_ROW: begin
          ma_q    <= ma_col;
          state_q <= ST_COL;
        end
        ST_COL: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Open page tracking
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      open_q      <= 1'b0;
      open_row_q  <= 3'h0;
      open_page_q <= '0;
    end else if (go_dram) begin
      open_q      <= 1'b1;
      open_row_q  <= row_idx;
      open_page_q <= page;
    end else if (hold_idle && idle_close) begin
      open_q      <= 1'b0;
    end
  end

  wire sd_cur = cur_type_q == SYNC_DRAM_TYPE;

  assign o_req_ready         = state_q == ST_IDLE;
  assign o_mux_address_lines = ma_q;
  assign o_bank_select_low   = sd_cur && ma_q[11];
  assign o_bank_select_high  = sd_cur && i_sdram_64m_en && ma_q[12];
  assign o_row_phase         = state_q == ST_ROW;
  assign o_col_phase         = state_q == ST_COL;
  assign o_row_sel           = sel_q;
  assign o_row_pin4          = i_sdram_64m_en ? o_bank_select_high : sel_q[4];
  assign o_row_pin5          = i_sdram_64m_en ? ma_q[13] : sel_q[5];
  assign o_row_type          = cur_type_q;
  assign o_early_cas_release = cur_type_q == EXTENDED_DATA_OUT_TYPE;
  assign o_status            = stat_q;
  assign o_fwd_pci           = fwd_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  chk_row_map: assert property (
    o_row_phase |-> ma_q[10:0] == req_q.addr[22:12] && ma_q[11] == req_q.addr[11] && ma_q[12] == req_q.addr[23])
    else $error("row phase address map wrong");

  chk_col_low: assert property (
    o_col_phase |-> ma_q[7:0] == req_q.addr[10:3] && ma_q[12] == req_q.addr[23])
    else $error("column phase low lines wrong");

  chk_sdram_v: assert property (
    (state_q == ST_ROW && type_q[row_q] == SYNC_DRAM_TYPE) |=> o_col_phase && ma_q[10] == $past(i_sdram_init))
    else $error("sync column line 10 wrong");

  chk_bank_high: assert property (
    !i_sdram_64m_en |-> !o_bank_select_high)
    else $error("upper bank select without 64-Mbit");

  chk_ma13_off: assert property (
    (!i_sdram_64m_en && !$past(i_sdram_64m_en) && !$past(i_sdram_64m_en, 2)) |-> !ma_q[13])
    else $error("line 13 driven without 64-Mbit");

  chk_keep_open: assert property (
    open_q && i_keep_open && hold_idle |=> open_q)
    else $error("page closed while policy keeps it");

  chk_idle_close: assert property (
    open_q && hold_idle && idle_close |=> !open_q)
    else $error("page left open on idle");

  chk_pci_fwd: assert property (
    accept && |i_req.addr[31:SPACE_LSB] |=> o_fwd_pci && o_status.to_pci && !o_status.cacheable && o_req_ready)
    else $error("access beyond space not forwarded");

  chk_hit_skip: assert property (
    go_dram && page_hit |=> o_col_phase ##1 o_req_ready)
    else $error("page hit did not skip row phase");

  chk_miss_seq: assert property (
    go_dram && !page_hit |=> o_row_phase ##1 o_col_phase ##1 o_req_ready)
    else $error("miss sequence wrong");

  chk_reset_fpm: assert property (
    $rose(i_rst_b) |-> type_q[0] == FAST_PAGE_TYPE && type_q[ROWS-1] == FAST_PAGE_TYPE)
    else $error("rows not fast page after reset");

  // Decode, classification and pin checks
  chk_gap_fwd: assert property (
    accept && i_gap_en && i_req.addr[31:20] == GAP_MB |=> o_fwd_pci && o_status.to_pci && !o_status.cacheable)
    else $error("enabled gap not forwarded");

  chk_video_smm: assert property (
    accept && video_smm && !above_top |=> !o_fwd_pci && !o_status.to_pci && !o_status.cacheable)
    else $error("system management video access wrong");

  chk_seg_uncached: assert property (
    accept && low_seg && !to_pci && !i_seg_cache[seg_idx] |=> !o_status.cacheable)
    else $error("disabled segment marked cacheable");

  chk_row_top: assert property (
    o_row_phase && i_sdram_64m_en && $past(i_sdram_64m_en) |-> ma_q[13] == req_q.addr[24])
    else $error("row line 13 wrong with 64-Mbit");

  chk_row_onehot: assert property (
    go_dram |=> $onehot(o_row_sel))
    else $error("row select not one-hot");

  chk_hit_v: assert property (
    go_dram && page_hit && use_sd |=> ma_q[10] == $past(i_sdram_init))
    else $error("sync hit column line 10 wrong");

  chk_hit_class: assert property (
    go_dram && page_hit |=> o_status.page_hit && !o_status.page_miss && !o_status.row_miss)
    else $error("page hit status wrong");

  chk_pci_quiet: assert property (
    accept && to_pci |=> !o_row_phase && !o_col_phase && o_row_sel == '0 && o_req_ready)
    else $error("forwarded access touched memory");

  chk_miss_class: assert property (
    go_dram && page_miss |=> o_status.page_miss && o_row_phase)
    else $error("page miss status wrong");

  cov_page_hit:  cover property (go_dram && page_hit);
  cov_page_miss: cover property (go_dram && page_miss ##1 o_row_phase ##1 o_col_phase);
  cov_pci:       cover property (accept && to_pci ##1 o_fwd_pci);
  cov_sdram_col: cover property (o_col_phase && sd_cur && i_sdram_64m_en);
  cov_video_smm: cover property (accept && video_smm);
endmodule
`default_nettype wire

// ---- logic/dat_pkg.sv ----
// Constants, types and carriers for the DRAM address translation block
`default_nettype none
package dat_pkg;
  localparam int ROWS       = 6;
  localparam int MA_W       = 14;
  localparam int GEOM_W     = 2;
  localparam int BOUND_W    = 8;
  localparam int PAGE_BYTES = 2048;
  localparam int PAGE_LSB   = $clog2(PAGE_BYTES);
  localparam int MAX_MB     = 256;
  localparam int UNIT_MB    = 4;
  localparam int UNIT_LSB   = 22;
  localparam int SPACE_LSB  = $clog2(MAX_MB) + 20;

  localparam logic [14:0] VIDEO_BLK     = 15'h0005;
  localparam int          VIDEO_LSB     = 17;
  localparam logic [11:0] GAP_MB        = 12'h00f;
  localparam logic [11:0] LOW_MB        = 12'h000;
  localparam logic [1:0]  SEG_WIN       = 2'h3;
  localparam int          SEG_LSB       = 14;
  localparam int          SEGS          = 16;

  typedef enum logic [1:0] {
    FAST_PAGE_TYPE,
    EXTENDED_DATA_OUT_TYPE,
    SYNC_DRAM_TYPE
  } dat_mem_e;

  localparam dat_mem_e TYPE_RESET = FAST_PAGE_TYPE;
  localparam logic [GEOM_W-1:0] GEOM_RESET = 2'h0;

  typedef enum {
    ST_IDLE,
    ST_ROW,
    ST_COL
  } dat_state_e;

  typedef struct packed {
    logic [31:3] addr;
    logic        from_pci;
  } dat_req_s;

  typedef struct packed {
    logic page_hit;
    logic page_miss;
    logic row_miss;
    logic to_pci;
    logic cacheable;
  } dat_stat_s;

  typedef logic [ROWS-1:0][BOUND_W-1:0] dat_bound_t;
  typedef logic [ROWS-1:0][GEOM_W-1:0]  dat_geom_t;
  typedef dat_mem_e [ROWS-1:0]           dat_type_t;
endpackage
`default_nettype wire

// ---- verif/dat_mem_rows_model.sv ----
// Behavioural memory rows that latch row and column addresses on their phases
`default_nettype none
module dat_mem_rows_model (
  input  wire logic        i_core_clk,
  input  wire logic [13:0] i_mux_address_lines,
  input  wire logic        i_row_phase,
  input  wire logic        i_col_phase,
  input  wire logic        i_early_cas_release,
  output logic [13:0]      o_row_addr,
  output logic [13:0]      o_col_addr,
  output logic             o_data_held
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_core_clk) begin
    if (i_row_phase) o_row_addr <= i_mux_address_lines;
    if (i_col_phase) o_col_addr <= i_mux_address_lines;
    // Extended rows keep data valid past the strobe release
    if (i_col_phase) o_data_held <= i_early_cas_release;
  end
endmodule
`default_nettype wire

// ---- verif/dram_address_translate_paging_bench.sv ----
// Self-checking bench for the DRAM address translation block
`default_nettype none
module dram_address_translate_paging_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dat_pkg::*;
  logic       clk, rst_b, valid, keep, hbusy, powner, m64, init, ld;
  logic       ready, rph, cph, bsl, bsh, p4, p5, ecr, fwd, held;
  dat_req_s   req;
  dat_bound_t bound;
  dat_type_t  rtype;
  dat_geom_t  geom;
  dat_mem_e   otype;
  dat_stat_s  st;
  logic [13:0] ma, mrow, mcol;
  logic [5:0]  sel;
  logic        smm, smr, gap;
  logic [15:0] segc;
  int          fail_count, samples_checked;

  dat_translate dat_translate_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_req_valid(valid),
    .o_req_ready(ready), .i_keep_open(keep), .i_host_busy(hbusy), .i_pci_owner(powner),
    .i_sdram_64m_en(m64), .i_sdram_init(init), .i_smm_access(smm), .i_smram_en(smr), .i_gap_en(gap),
    .i_seg_cache(segc), .i_row_bound(bound), .i_cfg_load(ld), .i_row_type(rtype), .i_row_geom(geom),
    .o_mux_address_lines(ma), .o_bank_select_low(bsl), .o_bank_select_high(bsh), .o_row_phase(rph),
    .o_col_phase(cph), .o_row_sel(sel), .o_row_pin4(p4), .o_row_pin5(p5), .o_row_type(otype),
    .o_early_cas_release(ecr), .o_status(st), .o_fwd_pci(fwd));
  dat_mem_rows_model dat_mem_rows_model_inst (.i_core_clk(clk), .i_mux_address_lines(ma),
    .i_row_phase(rph), .i_col_phase(cph), .i_early_cas_release(ecr), .o_row_addr(mrow),
    .o_col_addr(mcol), .o_data_held(held));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [13:0] row_exp(input logic [31:0] a);
    return {m64 & a[24], a[23], a[11], a[22:12]};
  endfunction

  function automatic logic [12:0] col_exp(input logic [31:0] a, input logic [1:0] g, input logic sd);
    logic c8;
    c8 = (g == 2'h0) ? a[11] : (g == 2'h1) ? a[22] : (g == 2'h2) ? a[23] : a[25];
    return {a[23], (g == 2'h0) ? a[26] : a[11], sd ? init : ((g == 2'h0) ? a[11] : a[25]),
            (g == 2'h0) ? a[11] : (g == 2'h1) ? a[24] : a[26], c8, a[10:3]};
  endfunction

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error %0t %s", $time, m);
    end
  endtask

  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic send(input logic [31:0] a, input logic pci);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 8) begin
        fail_count++;
        $display("Error %0t ready timeout", $time);
        close_out();
      end
    end
    req.addr = a[31:3];
    req.from_pci = pci;
    valid = 1'b1;
    @(posedge clk);
    #1;
    valid = 1'b0;
  endtask

  task automatic dram(input logic [31:0] a, input logic hit, input logic [1:0] g, input logic sd);
    send(a, 1'b0);
    if (!hit) begin
      chk(rph === 1'b1 && ready === 1'b0 && cph === 1'b0, "row phase");
      @(posedge clk);
      #1;
    end
    chk(cph === 1'b1 && rph === 1'b0, "col phase");
    @(posedge clk);
    #1;
    chk(ready === 1'b1 && cph === 1'b0, "ready back");
    chk(mcol[12:0] === col_exp(a, g, sd), "col address");
    if (!hit) chk(mrow === row_exp(a), "row address");
  endtask

  task automatic t_map;
    chk(ready === 1'b1 && st === 5'h00 && otype === FAST_PAGE_TYPE, "reset state");
    dram(32'h00a5_6788, 1'b0, 2'h0, 1'b0);
    chk(st.row_miss === 1'b1 && sel === 6'h02 && otype === FAST_PAGE_TYPE, "row miss");
    dram(32'h00a5_6018, 1'b1, 2'h0, 1'b0);
    chk(st.page_hit === 1'b1 && st.cacheable === 1'b1, "page hit");
    dram(32'h00a5_6f08, 1'b0, 2'h0, 1'b0);
    chk(st.page_miss === 1'b1, "page miss");
    $display("test map done");
  endtask

  task automatic t_close;
    keep = 1'b0;
    hbusy = 1'b1;
    dram(32'h00a5_6f40, 1'b1, 2'h0, 1'b0);
    hbusy = 1'b0;
    powner = 1'b1;
    dram(32'h00a5_6f48, 1'b1, 2'h0, 1'b0);
    powner = 1'b0;
    repeat (2) @(posedge clk);
    dram(32'h00a5_6f50, 1'b0, 2'h0, 1'b0);
    chk(st.row_miss === 1'b1, "page closed");
    $display("test close done");
  endtask

  task automatic t_pci;
    logic [31:0] adr [3] = '{32'h0400_0000, 32'h1000_0000, 32'h000a_0000};
    foreach (adr[i]) begin
      send(adr[i], 1'b1);
      chk(fwd === 1'b1 && st.to_pci === 1'b1 && st.cacheable === 1'b0 && ready === 1'b1, "pci");
      @(posedge clk);
      #1;
      chk(fwd === 1'b0 && rph === 1'b0, "pci pulse");
    end
    $display("test pci done");
  endtask

  task automatic t_decode;
    gap = 1'b1;
    send(32'h00f0_0000, 1'b0);
    chk(fwd === 1'b1 && st.to_pci === 1'b1 && st.cacheable === 1'b0, "gap forwarded");
    gap = 1'b0;
    dram(32'h00f0_0008, 1'b0, 2'h0, 1'b0);
    chk(st.to_pci === 1'b0 && st.cacheable === 1'b1 && sel === 6'h02, "gap closed");
    smm = 1'b1;
    smr = 1'b1;
    dram(32'h000a_0010, 1'b0, 2'h0, 1'b0);
    chk(st.to_pci === 1'b0 && st.cacheable === 1'b0 && sel === 6'h01, "smm video");
    smm = 1'b0;
    segc = 16'h0001;
    dram(32'h000c_0000, 1'b0, 2'h0, 1'b0);
    chk(st.cacheable === 1'b1, "segment cached");
    dram(32'h000c_4000, 1'b0, 2'h0, 1'b0);
    chk(st.cacheable === 1'b0 && st.to_pci === 1'b0, "segment uncached");
    $display("test decode done");
  endtask

  task automatic t_types;
    keep = 1'b1;
    rtype[2] = SYNC_DRAM_TYPE;
    geom[2] = 2'h1;
    rtype[3] = EXTENDED_DATA_OUT_TYPE;
    geom[3] = 2'h2;
    geom[4] = 2'h3;
    m64 = 1'b1;
    init = 1'b1;
    @(posedge clk);
    #1;
    ld = 1'b1;
    @(posedge clk);
    #1;
    ld = 1'b0;
    dram(32'h0123_4568, 1'b0, 2'h1, 1'b1);
    chk(otype === SYNC_DRAM_TYPE && bsl === 1'b0 && bsh === 1'b0, "bank selects");
    chk(p4 === 1'b0 && p5 === 1'b0 && mrow[13] === 1'b1, "row pins");
    init = 1'b0;
    dram(32'h0123_4d68, 1'b0, 2'h1, 1'b1);
    dram(32'h0123_4d70, 1'b1, 2'h1, 1'b1);
    chk(bsl === 1'b1 && bsh === 1'b0 && st.page_hit === 1'b1, "bank low");
    dram(32'h01a0_0010, 1'b0, 2'h2, 1'b0);
    chk(ecr === 1'b1 && held === 1'b1 && otype === EXTENDED_DATA_OUT_TYPE && bsl === 1'b0, "edo row");
    dram(32'h0200_0018, 1'b0, 2'h3, 1'b0);
    chk(ecr === 1'b0 && sel === 6'h10 && p4 === 1'b0, "fast row");
    $display("test types done");
  endtask

  initial begin
    {rst_b, valid, keep, hbusy, powner, m64, init, ld} = 8'h20;
    req = '0;
    {smm, smr, gap} = 3'h0;
    segc = 16'h0000;
    rtype = '{default: FAST_PAGE_TYPE};
    geom = '0;
    foreach (bound[r]) bound[r] = 8'((r + 1) * 2);
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_map();
    t_close();
    t_pci();
    t_decode();
    t_types();
    close_out();
  end
endmodule
`default_nettype wire
